/* core/gdsfm_pkg.sv */
// Package with register map, field layout, reset values and timing constants of the supply fault monitor.
package gdsfm_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;

  // Least times round up to whole cycles and never fall below one cycle.
  function automatic int ceil_cycles(input int time_ns);
    int c;
    c = (time_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int MUTE_TIME_NS = 10000;
  localparam int MUTE_CYC = ceil_cycles(MUTE_TIME_NS);
  localparam int DEGLITCH_BASE_NS = 1000;
  localparam int DEGLITCH_BASE_CYC = ceil_cycles(DEGLITCH_BASE_NS);
  localparam int DEAD_BASE_NS = 15;
  localparam int DEAD_BASE_CYC = ceil_cycles(DEAD_BASE_NS);
  localparam int DEAD_STEP_NS = 20;
  localparam int DEAD_STEP_CYC = ceil_cycles(DEAD_STEP_NS);
  localparam int ILIM_DEGLITCH_NS = 30000;
  localparam int ILIM_DEGLITCH_CYC = ceil_cycles(ILIM_DEGLITCH_NS);
  localparam int STARTUP_TIME_US = 2000;
  localparam int STARTUP_CYC_DEFAULT = STARTUP_TIME_US * 1000 / CLK_PERIOD_NS;

  localparam int FILT_W = 16;
  localparam int DEAD_W = 8;
  localparam int MUTE_W = 16;
  localparam int START_W = 24;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_PRI_STATUS = 8'h00;
  localparam logic [7:0] OFF_SEC_STATUS = 8'h04;
  localparam logic [7:0] OFF_FAULT_MASK = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0c;
  localparam logic [7:0] OFF_FAILSAFE = 8'h10;
  localparam logic [7:0] OFF_STATE = 8'h14;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int PRI_UV_BIT = 0;
  localparam int PRI_OV_BIT = 1;
  localparam int PRI_REG_OC_BIT = 2;
  localparam int PRI_RAIL_BIT = 3;
  localparam int PRI_FLAGS_W = 4;
  localparam int SEC_POS_UV_BIT = 0;
  localparam int SEC_POS_OV_BIT = 1;
  localparam int SEC_NEG_UV_BIT = 2;
  localparam int SEC_NEG_OV_BIT = 3;
  localparam int SEC_WARN_BIT = 4;
  localparam int SEC_FLAGS_W = 5;
  localparam int SEC_FAULT_W = 4;
  localparam int MASK_W = PRI_FLAGS_W + SEC_FAULT_W;
  localparam int CTRL_MUTE_BIT = 0;
  localparam int CTRL_DEAD_LSB = 1;
  localparam int CTRL_DEAD_W = 6;
  localparam int CTRL_DEGL_LSB = 8;
  localparam int CTRL_DEGL_W = 2;
  localparam int FS_SEL_BIT = 0;
  localparam int ST_SHUTDOWN_BIT = 0;
  localparam int ST_COMM_LOSS_BIT = 1;
  localparam int ST_MUTED_BIT = 2;
  localparam int ST_STARTED_BIT = 3;
  localparam int ST_GATE_LSB = 4;
  localparam int ST_FAULT_PIN_BIT = 6;
  localparam int ST_WARN_PIN_BIT = 7;

  // ****************************************
  // Reset values and bus answers
  // ****************************************
  localparam logic RST_MUTE_EN = 1'b0;
  localparam logic [5:0] RST_DEAD_CODE = 6'h00;
  localparam logic [1:0] RST_DEGL_CODE = 2'h0;
  localparam logic [MASK_W-1:0] RST_MASK = 8'h00;
  localparam logic RST_FS_SEL = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* core/gdsfm_filter.sv */
// Deglitch filter: the output follows the input only after it has stood still for a set number of cycles.
`timescale 1ns/1ps
module gdsfm_filter (
  input wire logic core_clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic raw, // Unfiltered input level.
  input wire logic [gdsfm_pkg::FILT_W-1:0] limit, // Cycles the input must hold, at least one.
  output logic clean // Filtered level.
);

  typedef struct packed {
    logic clean;
    logic [gdsfm_pkg::FILT_W-1:0] cnt;
  } gdsfm_filt_t;

  gdsfm_filt_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (raw == s_q.clean) begin
      s_d.cnt = '0;
    end else if (s_q.cnt + 1'b1 >= limit) begin
      s_d.clean = raw;
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign clean = s_q.clean;

endmodule // gdsfm_filter

/* core/gdsfm_dead_time.sv */
// Dead-time generator: both gate drivers stay off for a programmed time before either side turns on.
`timescale 1ns/1ps
module gdsfm_dead_time (
  input wire logic core_clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic demand, // Wanted gate state, high means on.
  input wire logic [gdsfm_pkg::DEAD_W-1:0] dead_cycles, // Off time between the two sides.
  output logic gate_on, // Turn-on driver active.
  output logic gate_off // Turn-off driver active.
);

  typedef struct packed {
    logic on;
    logic off;
    logic [gdsfm_pkg::DEAD_W-1:0] cnt;
  } gdsfm_dead_t;

  gdsfm_dead_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (demand ? s_q.off : s_q.on) begin
      s_d.on = 1'b0;
      s_d.off = 1'b0;
      s_d.cnt = dead_cycles;
    end else if (!s_q.on && !s_q.off) begin
      if (s_q.cnt > 1) begin
        s_d.cnt = s_q.cnt - 1'b1;
      end else begin
        s_d.cnt = '0;
        s_d.on = demand;
        s_d.off = !demand;
      end
    end
  end

  // Reset parks the gate in the off state, never both drivers at once.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{on: 1'b0, off: 1'b1, cnt: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign gate_on = s_q.on;
  assign gate_off = s_q.off;

endmodule // gdsfm_dead_time

/* core/gdsfm_top.sv */
// Supply fault monitor, protection timing and gate path of an isolated gate driver, with AXI4-Lite registers.
//
// Notes on behaviour
// - Primary logic supply under- and overvoltage each set their own status flag.
// - Positive drive supply under- and overvoltage each set a secondary status flag.
// - Negative drive supply under- and overvoltage each set a secondary status flag.
// - Regulator current limit held through the deglitch interval sets the overcurrent flag.
// - Unmasked recorded faults pull the fault alarm low; masked faults other than regulator overvoltage leave it alone.
// - Primary regulator undervoltage sets the shared internal rail flag.
// - Primary regulator overvoltage latches the device off until power is cycled.
// - After that shutdown, communication loss forces the gate to the failsafe state.
// - With mute enabled, PWM is ignored for the mute time after protection faults.
// - A six-bit code selects the shoot-through dead time.
// - Primary control inputs are deglitched by an interval chosen by a two-bit code.
// - Both alarm outputs stay low until the start-up interval after supplies are ready.
// - A warning-class fault drives the warning alarm low within its delay.
// - Primary and secondary short-circuit inputs switch the gate within a bounded delay.
// - Supply, regulator and warning faults show on open-drain pins and stay readable over the bus; regulator under- and overvoltage share one flag.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module gdsfm_top #(
  parameter int STARTUP_CYCLES = gdsfm_pkg::STARTUP_CYC_DEFAULT // Start-up interval in clock cycles.
) (
  input wire logic core_clk, // System clock, 100 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic primary_logic_supply_uv, // Primary supply undervoltage comparator.
  input wire logic primary_logic_supply_ov, // Primary supply overvoltage comparator.
  input wire logic positive_drive_supply_uv, // Positive drive supply undervoltage comparator.
  input wire logic positive_drive_supply_ov, // Positive drive supply overvoltage comparator.
  input wire logic negative_drive_supply_uv, // Negative drive supply undervoltage comparator.
  input wire logic negative_drive_supply_ov, // Negative drive supply overvoltage comparator.
  input wire logic primary_internal_regulator_ilimit, // Regulator current limit active.
  input wire logic primary_internal_regulator_uv, // Regulator undervoltage comparator.
  input wire logic primary_internal_regulator_ov, // Regulator overvoltage comparator.
  input wire logic supplies_ready, // All supplies have reached their ready level.
  input wire logic warning_fault, // Warning-class fault detected.
  input wire logic desaturation_fault, // Desaturation fault.
  input wire logic shunt_short_fault, // Shunt short-circuit fault.
  input wire logic primary_thermal_shutdown, // Primary thermal shutdown.
  input wire logic pwm_in, // PWM input from the host.
  input wire logic short_circuit_command, // Primary active short-circuit command.
  input wire logic short_circuit_enable, // Primary active short-circuit enable.
  input wire logic secondary_short_circuit_input, // Secondary short-circuit control input.
  input wire logic fault_alarm_n_i, // Fault alarm pin level.
  output logic fault_alarm_n_o, // Fault alarm drive value.
  output logic fault_alarm_n_oe_n, // Fault alarm enable, low while pulling low.
  input wire logic warning_alarm_n_i, // Warning alarm pin level.
  output logic warning_alarm_n_o, // Warning alarm drive value.
  output logic warning_alarm_n_oe_n, // Warning alarm enable, low while pulling low.
  output logic [1:0] gate_outputs // Bit 1 turn-on driver, bit 0 turn-off driver.
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [gdsfm_pkg::PRI_FLAGS_W-1:0] pri_flags;
    logic [gdsfm_pkg::SEC_FLAGS_W-1:0] sec_flags;
    logic [gdsfm_pkg::MASK_W-1:0] mask;
    logic mute_en;
    logic [gdsfm_pkg::CTRL_DEAD_W-1:0] dead_code;
    logic [gdsfm_pkg::CTRL_DEGL_W-1:0] degl_code;
    logic fs_sel;
    logic shutdown;
    logic comm_loss;
    logic [gdsfm_pkg::MUTE_W-1:0] mute_cnt;
    logic [gdsfm_pkg::START_W-1:0] start_cnt;
    logic started;
    logic fault_low;
    logic warn_low;
    logic [1:0] gate;
  } gdsfm_state_t;

  gdsfm_state_t s_q, s_d;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a == gdsfm_pkg::OFF_PRI_STATUS || a == gdsfm_pkg::OFF_SEC_STATUS || a == gdsfm_pkg::OFF_FAULT_MASK
        || a == gdsfm_pkg::OFF_CTRL || a == gdsfm_pkg::OFF_FAILSAFE || a == gdsfm_pkg::OFF_STATE;
  endfunction

  // Deglitch length doubles with each code step, code zero being the base interval.
  function automatic logic [gdsfm_pkg::FILT_W-1:0] deglitch_cycles(input logic [1:0] code);
    return gdsfm_pkg::FILT_W'(gdsfm_pkg::DEGLITCH_BASE_CYC << code);
  endfunction

  function automatic logic [gdsfm_pkg::DEAD_W-1:0] dead_cycles(input logic [5:0] code);
    return gdsfm_pkg::DEAD_W'(gdsfm_pkg::DEAD_BASE_CYC + int'(code) * gdsfm_pkg::DEAD_STEP_CYC);
  endfunction

  // ****************************************
  // Filtered inputs and gate timing
  // ****************************************
  logic pwm_f, sc_cmd_f, sc_en_f, ilim_f, demand, dt_on, dt_off;
  logic [gdsfm_pkg::FILT_W-1:0] io_limit;

  assign io_limit = deglitch_cycles(s_q.degl_code);

  gdsfm_filter u_pwm_filter (
    .core_clk(core_clk),
    .rst(rst),
    .raw(pwm_in),
    .limit(io_limit),
    .clean(pwm_f)
  );

  gdsfm_filter u_sc_cmd_filter (
    .core_clk(core_clk),
    .rst(rst),
    .raw(short_circuit_command),
    .limit(io_limit),
    .clean(sc_cmd_f)
  );

  gdsfm_filter u_sc_en_filter (
    .core_clk(core_clk),
    .rst(rst),
    .raw(short_circuit_enable),
    .limit(io_limit),
    .clean(sc_en_f)
  );

  // The current limit must hold for the whole interval before it counts as a fault.
  gdsfm_filter u_ilim_filter (
    .core_clk(core_clk),
    .rst(rst),
    .raw(primary_internal_regulator_ilimit),
    .limit(gdsfm_pkg::FILT_W'(gdsfm_pkg::ILIM_DEGLITCH_CYC)),
    .clean(ilim_f)
  );

  gdsfm_dead_time u_dead_time (
    .core_clk(core_clk),
    .rst(rst),
    .demand(demand),
    .dead_cycles(dead_cycles(s_q.dead_code)),
    .gate_on(dt_on),
    .gate_off(dt_off)
  );

  // Failsafe wins over everything, then short circuit, then mute, then PWM.
  always_comb begin
    if (s_q.comm_loss) begin
      demand = s_q.fs_sel;
    end else if ((sc_en_f && sc_cmd_f) || secondary_short_circuit_input) begin
      demand = 1'b1;
    end else if (s_q.mute_cnt != '0) begin
      demand = 1'b0;
    end else begin
      demand = pwm_f;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  logic aw_take, w_take, ar_take;
  logic [7:0] wr_addr;
  logic [31:0] wr_data, wr_img, rd_img;
  logic [3:0] wr_strb;
  logic do_write;
  logic [gdsfm_pkg::PRI_FLAGS_W-1:0] pri_set, pri_clr;
  logic [gdsfm_pkg::SEC_FLAGS_W-1:0] sec_set, sec_clr;
  logic trip;

  always_comb begin
    s_d = s_q;
    aw_take = s_axi_awvalid && s_q.awready;
    w_take = s_axi_wvalid && s_q.wready;
    ar_take = s_axi_arvalid && s_q.arready;
    wr_addr = aw_take ? s_axi_awaddr : s_q.aw_addr;
    wr_data = w_take ? s_axi_wdata : s_q.w_data;
    wr_strb = w_take ? s_axi_wstrb : s_q.w_strb;
    do_write = (s_q.aw_got || aw_take) && (s_q.w_got || w_take) && !s_q.bvalid;
    pri_clr = '0;
    sec_clr = '0;
    wr_img = '0;

    // Hardware sets the fault flags from the comparators every cycle.
    pri_set = '0;
    pri_set[gdsfm_pkg::PRI_UV_BIT] = primary_logic_supply_uv;
    pri_set[gdsfm_pkg::PRI_OV_BIT] = primary_logic_supply_ov;
    pri_set[gdsfm_pkg::PRI_REG_OC_BIT] = ilim_f;
    pri_set[gdsfm_pkg::PRI_RAIL_BIT] = primary_internal_regulator_uv || primary_internal_regulator_ov;
    sec_set = '0;
    sec_set[gdsfm_pkg::SEC_POS_UV_BIT] = positive_drive_supply_uv;
    sec_set[gdsfm_pkg::SEC_POS_OV_BIT] = positive_drive_supply_ov;
    sec_set[gdsfm_pkg::SEC_NEG_UV_BIT] = negative_drive_supply_uv;
    sec_set[gdsfm_pkg::SEC_NEG_OV_BIT] = negative_drive_supply_ov;
    sec_set[gdsfm_pkg::SEC_WARN_BIT] = warning_fault;

    // Write channel: address and data are taken in either order.
    if (aw_take) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      s_d.w_got = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = is_mapped(wr_addr) ? gdsfm_pkg::RESP_OKAY : gdsfm_pkg::RESP_SLVERR;
      wr_img = merge_strb(32'h0000_0000, wr_data, wr_strb);
      case (wr_addr)
        gdsfm_pkg::OFF_PRI_STATUS: begin
          pri_clr = wr_img[gdsfm_pkg::PRI_FLAGS_W-1:0];
        end
        gdsfm_pkg::OFF_SEC_STATUS: begin
          sec_clr = wr_img[gdsfm_pkg::SEC_FLAGS_W-1:0];
        end
        gdsfm_pkg::OFF_FAULT_MASK: begin
          wr_img = merge_strb(32'(s_q.mask), wr_data, wr_strb);
          s_d.mask = wr_img[gdsfm_pkg::MASK_W-1:0];
        end
        gdsfm_pkg::OFF_CTRL: begin
          wr_img = merge_strb({22'h000000, s_q.degl_code, 1'b0, s_q.dead_code, s_q.mute_en}, wr_data, wr_strb);
          s_d.mute_en = wr_img[gdsfm_pkg::CTRL_MUTE_BIT];
          s_d.dead_code = wr_img[gdsfm_pkg::CTRL_DEAD_LSB +: gdsfm_pkg::CTRL_DEAD_W];
          s_d.degl_code = wr_img[gdsfm_pkg::CTRL_DEGL_LSB +: gdsfm_pkg::CTRL_DEGL_W];
        end
        gdsfm_pkg::OFF_FAILSAFE: begin
          wr_img = merge_strb({31'h0000_0000, s_q.fs_sel}, wr_data, wr_strb);
          s_d.fs_sel = wr_img[gdsfm_pkg::FS_SEL_BIT];
        end
        default: begin
          wr_img = '0;
        end
      endcase
    end else if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;

    // Flags are sticky; a set in the clearing cycle wins over the clear.
    s_d.pri_flags = (s_q.pri_flags & ~pri_clr) | pri_set;
    s_d.sec_flags = (s_q.sec_flags & ~sec_clr) | sec_set;

    // Read channel.
    rd_img = '0;
    case (s_axi_araddr)
      gdsfm_pkg::OFF_PRI_STATUS: rd_img = 32'(s_q.pri_flags);
      gdsfm_pkg::OFF_SEC_STATUS: rd_img = 32'(s_q.sec_flags);
      gdsfm_pkg::OFF_FAULT_MASK: rd_img = 32'(s_q.mask);
      gdsfm_pkg::OFF_CTRL: rd_img = {22'h000000, s_q.degl_code, 1'b0, s_q.dead_code, s_q.mute_en};
      gdsfm_pkg::OFF_FAILSAFE: rd_img = {31'h0000_0000, s_q.fs_sel};
      gdsfm_pkg::OFF_STATE: begin
        rd_img[gdsfm_pkg::ST_SHUTDOWN_BIT] = s_q.shutdown;
        rd_img[gdsfm_pkg::ST_COMM_LOSS_BIT] = s_q.comm_loss;
        rd_img[gdsfm_pkg::ST_MUTED_BIT] = s_q.mute_cnt != '0;
        rd_img[gdsfm_pkg::ST_STARTED_BIT] = s_q.started;
        rd_img[gdsfm_pkg::ST_GATE_LSB +: 2] = s_q.gate;
        rd_img[gdsfm_pkg::ST_FAULT_PIN_BIT] = fault_alarm_n_i;
        rd_img[gdsfm_pkg::ST_WARN_PIN_BIT] = warning_alarm_n_i;
      end
      default: rd_img = '0;
    endcase
    if (ar_take) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_img;
      s_d.rresp = is_mapped(s_axi_araddr) ? gdsfm_pkg::RESP_OKAY : gdsfm_pkg::RESP_SLVERR;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end

    // Regulator overvoltage latches off; only reset, that is a power cycle, brings it back.
    s_d.shutdown = s_q.shutdown || primary_internal_regulator_ov;
    // The secondary side sees the link drop one cycle after the primary shuts down.
    s_d.comm_loss = s_q.comm_loss || s_q.shutdown;

    // Mute restarts while any protection fault is present.
    trip = desaturation_fault || shunt_short_fault || primary_thermal_shutdown;
    if (s_q.mute_en && trip) begin
      s_d.mute_cnt = gdsfm_pkg::MUTE_W'(gdsfm_pkg::MUTE_CYC);
    end else if (s_q.mute_cnt != '0) begin
      s_d.mute_cnt = s_q.mute_cnt - 1'b1;
    end

    // Start-up interval counts from supplies ready and restarts if they drop.
    if (!supplies_ready) begin
      s_d.start_cnt = '0;
      s_d.started = 1'b0;
    end else if (!s_q.started) begin
      s_d.start_cnt = s_q.start_cnt + 1'b1;
      s_d.started = s_q.start_cnt + 1'b1 >= gdsfm_pkg::START_W'(STARTUP_CYCLES);
    end

    // Alarm pins: low during start-up, then on unmasked faults or warnings.
    s_d.fault_low = !s_q.started || s_q.shutdown
                    || ((({s_q.sec_flags[gdsfm_pkg::SEC_FAULT_W-1:0], s_q.pri_flags}) & ~s_q.mask) != '0);
    s_d.warn_low = !s_q.started || s_q.sec_flags[gdsfm_pkg::SEC_WARN_BIT];
    s_d.gate = {dt_on, dt_off};
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.mask <= gdsfm_pkg::RST_MASK;
      s_q.mute_en <= gdsfm_pkg::RST_MUTE_EN;
      s_q.dead_code <= gdsfm_pkg::RST_DEAD_CODE;
      s_q.degl_code <= gdsfm_pkg::RST_DEGL_CODE;
      s_q.fs_sel <= gdsfm_pkg::RST_FS_SEL;
      s_q.fault_low <= 1'b1;
      s_q.warn_low <= 1'b1;
      s_q.gate <= 2'h1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  // Open-drain pins only ever pull low; the external pull-up makes the high level.
  assign fault_alarm_n_o = 1'b0;
  assign fault_alarm_n_oe_n = !s_q.fault_low;
  assign warning_alarm_n_o = 1'b0;
  assign warning_alarm_n_oe_n = !s_q.warn_low;
  assign gate_outputs = s_q.gate;

endmodule // gdsfm_top

/* test/gdsfm_checker.sv */
// Checker of the alarm pins, gate path and bus answers of the supply fault monitor.
`timescale 1ns/1ps
module gdsfm_checker (
  input wire logic core_clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic s_axi_awready, // Bus.
  input wire logic s_axi_bvalid, // Bus.
  input wire logic s_axi_bready, // Bus.
  input wire logic s_axi_arvalid, // Bus.
  input wire logic s_axi_arready, // Bus.
  input wire logic s_axi_rvalid, // Bus.
  input wire logic primary_logic_supply_uv, // Rail.
  input wire logic primary_internal_regulator_ov, // Rail.
  input wire logic supplies_ready, // Rails up.
  input wire logic warning_fault, // Warning.
  input wire logic secondary_short_circuit_input, // Short.
  input wire logic fault_alarm_n_oe_n, // Pin.
  input wire logic warning_alarm_n_oe_n, // Pin.
  input wire logic [1:0] gate_outputs // Gate.
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  gate_exclusive_a: assert property (gate_outputs != 2'h3) else $error("gate overlap");
  supply_pin_a: assert property (primary_logic_supply_uv |-> ##2 !fault_alarm_n_oe_n) else $error("fault pin");
  shutdown_pin_a: assert property (primary_internal_regulator_ov |-> ##3 !fault_alarm_n_oe_n [*8]) else $error("shutdown");
  warn_pin_a: assert property (warning_fault |-> ##2 !warning_alarm_n_oe_n) else $error("warning pin");
  startup_hold_a: assert property ($rose(supplies_ready) |-> !fault_alarm_n_oe_n [*8]) else $error("startup");
  sec_short_a: assert property ($rose(secondary_short_circuit_input) |-> ##[1:200] gate_outputs == 2'h2)
    else $error("short path");
  resp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw open");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (gate_outputs == 2'h2);
  cover property ($rose(fault_alarm_n_oe_n));
endmodule // gdsfm_checker
bind gdsfm_top gdsfm_checker chk (.*);

/* test/gdsfm_host.sv */
// Host controller model driving PWM and the short-circuit command lines.
`timescale 1ns/1ps
module gdsfm_host (
  input wire logic core_clk, // Clock.
  input wire logic pwm_en, // Run PWM.
  input wire logic sc_req, // Want short circuit.
  output logic pwm_in = 1'h0, // PWM.
  output logic short_circuit_command = 1'h0, // Command.
  output logic short_circuit_enable = 1'h0 // Enable.
);
  logic [9:0] cnt_q = 10'h000;
  always @(posedge core_clk) begin
    cnt_q <= cnt_q + 10'h001;
    pwm_in <= pwm_en & cnt_q[9];
    short_circuit_enable <= sc_req;
    short_circuit_command <= sc_req; // Moves with the enable, rising and falling with sc_req.
  end
endmodule // gdsfm_host

/* test/tb_top.sv */
// Self-checking bench of the supply fault monitor.
`timescale 1ns/1ps
module tb_top;
  logic core_clk = '0, rst = 1'h1, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
  logic s_axi_rready = '0, supplies_ready = '0, warning_fault = '0, secondary_short_circuit_input = '0;
  logic pwm_en = '0, sc_req = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic [8:0] flt = '0;
  logic fault_alarm_n_o, fault_alarm_n_oe_n, warning_alarm_n_o, warning_alarm_n_oe_n;
  logic pwm_in, short_circuit_command, short_circuit_enable;
  logic [1:0] s_axi_bresp, s_axi_rresp, gate_outputs;
  logic [33:0] exp_q[$];
  int bad_count = 0, comparisons = 0, i, c;
  wire desaturation_fault = '0, shunt_short_fault = '0, primary_thermal_shutdown = '0;
  wire primary_logic_supply_uv = flt[0], primary_logic_supply_ov = flt[1], positive_drive_supply_uv = flt[2];
  wire positive_drive_supply_ov = flt[3], negative_drive_supply_uv = flt[4], negative_drive_supply_ov = flt[5];
  wire primary_internal_regulator_uv = flt[6], primary_internal_regulator_ilimit = flt[7];
  wire primary_internal_regulator_ov = flt[8];
  // Alarm pins have pull-ups, so a released pin reads high.
  wire fault_alarm_n_i = fault_alarm_n_oe_n | fault_alarm_n_o;
  wire warning_alarm_n_i = warning_alarm_n_oe_n | warning_alarm_n_o;
  gdsfm_top #(.STARTUP_CYCLES(20)) DUT (.*);
  gdsfm_host host (.*);
  always #5 core_clk = ~core_clk;
  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  always @(posedge core_clk) if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) check({s_axi_rresp, s_axi_rdata},
    exp_q.pop_front());
  // One write (wr=1) or one read with its expected word; unmapped places answer with an error.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    if (!wr) exp_q.push_back({(a > 8'h14) ? 2'h2 : 2'h0, d});
    for (n = 0; n < 99; n++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
      if (s_axi_arready) s_axi_arvalid <= '0;
      if (s_axi_bvalid) s_axi_bready <= '0;
      if (s_axi_rvalid) s_axi_rready <= '0;
      if (!(s_axi_bready | s_axi_rready)) break;
    end
    if (n == 99) begin
      bad_count++;
      final_report();
    end
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  initial begin
    c = $urandom(2);
    hold(10);
    rst <= '0;
    hold(1);
    xfer(0, 8'h14, 32'h10);
    xfer(0, 8'h0c, '0);
    xfer(0, 8'h18, '0);
    supplies_ready <= 1'h1;
    hold(30);
    xfer(0, 8'h14, 32'hd8);
    $display("start-up done");
    pwm_en <= 1'h1;
    for (i = 0; i < 8; i++) begin
      flt[i] <= 1'h1;
      hold(3100);
      flt[i] <= '0;
      hold(3001);
      c = (i > 1 && i < 6) ? 4 : 0;
      xfer(0, c[7:0], 32'h1 << (i < 2 ? i : i < 6 ? i - 2 : 9 - i));
      xfer(1, c[7:0], 32'hff);
      xfer(0, c[7:0], '0);
    end
    pwm_en <= '0;
    xfer(1, 8'h08, 32'hff);
    flt[2] <= 1'h1;
    hold(300);
    flt[2] <= '0;
    xfer(0, 8'h14, 32'hd8);
    xfer(1, 8'h04, 32'hff);
    xfer(1, 8'h08, '0);
    warning_fault <= 1'h1;
    hold(3);
    warning_fault <= '0;
    xfer(0, 8'h04, 32'h10);
    xfer(1, 8'h04, 32'h10);
    $display("flags done");
    c = $urandom % 64;
    xfer(1, 8'h0c, c << 1);
    xfer(0, 8'h0c, c << 1);
    sc_req <= 1'h1;
    hold(300);
    xfer(0, 8'h14, 32'he8);
    sc_req <= '0;
    hold(300);
    secondary_short_circuit_input <= 1'h1;
    hold(300);
    xfer(0, 8'h14, 32'he8);
    secondary_short_circuit_input <= '0;
    xfer(1, 8'h10, 32'h1);
    flt[8] <= 1'h1;
    hold(300);
    xfer(0, 8'h14, 32'hab);
    flt <= '0;
    rst <= '1;
    hold(2);
    rst <= '0;
    xfer(0, 8'h14, 32'h10);
    $display("gate path done");
    final_report();
  end
endmodule // tb_top
